// ---- tcv_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
module tcv_channel import tcv_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// processor port
	input wire tcv_bus_t bus,
	output logic [7:0] rdata,
	// timer context
	input wire tcv_counter_t counter,
	input wire logic background_debug,
	// channel value to the comparator
	output logic [15:0] chan_value
);

	////////////////////////////////////////////////////////////////
	logic [7:0] chan_status_control;
	tcv_mode_t mode;
	logic [15:0] read_buf;
	logic read_latched;
	logic read_got_high;
	logic read_got_low;
	logic [7:0] wbuf_high;
	logic [7:0] wbuf_low;
	logic wgot_high;
	logic wgot_low;
	logic [1:0] clock_select;
	logic sc_write;
	logic val_write;
	logic val_read;
	logic is_high;
	logic pair_full;
	logic pwm_point;
	logic transfer;
	logic [15:0] pwm_top;

	function automatic logic addr_is_value(input logic [1:0] a);
		return (a == TCV_ADDR_VALUE_HIGH) || (a == TCV_ADDR_VALUE_LOW);
	endfunction

	assign clock_select = {chan_status_control[TCV_CS_CLKSEL_HI],
		chan_status_control[TCV_CS_CLKSEL_LO]};
	assign sc_write = bus.wr && (bus.addr == TCV_ADDR_STATUS_CONTROL);
	assign val_write = bus.wr && addr_is_value(bus.addr);
	assign val_read = bus.rd && addr_is_value(bus.addr);
	assign is_high = (bus.addr == TCV_ADDR_VALUE_HIGH);
	assign pwm_top = counter.free_run ? TCV_FREE_RUN_TOP : counter.modulo;
	assign pwm_point = counter.step &&
		(counter.count == (counter.free_run ? TCV_FREE_RUN_PRE :
		counter.modulo - TCV_ONE));
	assign pair_full = wgot_high && wgot_low;

	// transfer point depends on clock selection and mode
	always_comb begin
		transfer = 1'b0;
		if (pair_full && !background_debug) begin
			case (mode)
			TCV_MODE_COMPARE: begin
				transfer = (clock_select == TCV_CLKSEL_NONE) ||
					counter.step;
			end
			TCV_MODE_EDGE_PWM, TCV_MODE_CENTER_PWM: begin
				transfer = (clock_select == TCV_CLKSEL_NONE) ||
					pwm_point;
			end
			default: begin
				transfer = 1'b0;
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	// configuration registers
	always_ff @(posedge clock) begin
		if (!resetn) begin
			chan_status_control <= TCV_BYTE_RESET;
			mode <= TCV_MODE_CAPTURE;
		end else if (sc_write) begin
			chan_status_control <= bus.wdata;
		end else if (bus.wr && bus.addr == TCV_ADDR_MODE) begin
			mode <= tcv_mode_t'(bus.wdata[1:0]);
		end
	end

	////////////////////////////////////////////////////////////////
	// read coherency: outside debug in capture mode, latch both bytes on first read of a pair
	always_ff @(posedge clock) begin
		if (!resetn || sc_write) begin
			read_latched <= 1'b0;
			read_got_high <= 1'b0;
			read_got_low <= 1'b0;
			read_buf <= TCV_VALUE_RESET;
		end else if (val_read && !background_debug &&
			mode == TCV_MODE_CAPTURE) begin
			if (!read_latched) begin
				read_latched <= 1'b1;
				read_buf <= chan_value;
				read_got_high <= is_high;
				read_got_low <= !is_high;
			end else if ((is_high && read_got_low) ||
				(!is_high && read_got_high)) begin
				read_latched <= 1'b0;
				read_got_high <= 1'b0;
				read_got_low <= 1'b0;
			end
		end
	end

	// read data one cycle later
	always_ff @(posedge clock) begin
		if (!resetn) begin
			rdata <= TCV_BYTE_RESET;
		end else if (bus.rd) begin
			case (bus.addr)
			TCV_ADDR_STATUS_CONTROL: rdata <= chan_status_control;
			TCV_ADDR_MODE: rdata <= {6'h00, mode};
			TCV_ADDR_VALUE_HIGH: begin
				if (background_debug || mode != TCV_MODE_CAPTURE)
					rdata <= chan_value[15:8];
				else if (read_latched)
					rdata <= read_buf[15:8];
				else
					rdata <= chan_value[15:8];
			end
			TCV_ADDR_VALUE_LOW: begin
				if (background_debug || mode != TCV_MODE_CAPTURE)
					rdata <= chan_value[7:0];
				else if (read_latched)
					rdata <= read_buf[7:0];
				else
					rdata <= chan_value[7:0];
			end
			default: rdata <= TCV_BYTE_RESET;
			endcase
		end else begin
			rdata <= TCV_BYTE_RESET;
		end
	end

	////////////////////////////////////////////////////////////////
	// write coherency; debug value writes bypass and leave latch frozen
	always_ff @(posedge clock) begin
		if (!resetn || sc_write) begin
			wgot_high <= 1'b0;
			wgot_low <= 1'b0;
			wbuf_high <= TCV_BYTE_RESET;
			wbuf_low <= TCV_BYTE_RESET;
		end else if (background_debug) begin
			wgot_high <= wgot_high;
		end else begin
			// a byte in the copy cycle must not be lost: it opens the next pair
			if (transfer) begin
				wgot_high <= 1'b0;
				wgot_low <= 1'b0;
			end
			if (val_write && mode != TCV_MODE_CAPTURE) begin
				if (is_high) begin
					wbuf_high <= bus.wdata;
					wgot_high <= 1'b1;
				end else begin
					wbuf_low <= bus.wdata;
					wgot_low <= 1'b1;
				end
			end
		end
	end

	// channel register; capture source not modelled in this block
	always_ff @(posedge clock) begin
		if (!resetn) begin
			chan_value <= TCV_VALUE_RESET;
		end else if (val_write && background_debug &&
			mode != TCV_MODE_CAPTURE) begin
			if (is_high)
				chan_value[15:8] <= bus.wdata;
			else
				chan_value[7:0] <= bus.wdata;
		end else if (transfer) begin
			chan_value <= {wbuf_high, wbuf_low};
		end
	end

	////////////////////////////////////////////////////////////////
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);

	cap_write_ignored_a: assert property (
		mode == TCV_MODE_CAPTURE && val_write |=> $stable(chan_value))
		else $error("value changed by write in capture");
	sc_release_a: assert property (
		sc_write |=> !read_latched && !wgot_high && !wgot_low)
		else $error("status write did not release latches");
	read_latch_a: assert property (
		val_read && !read_latched && !background_debug &&
		mode == TCV_MODE_CAPTURE && !sc_write |=> read_latched)
		else $error("capture read did not latch");
	debug_read_frozen_a: assert property (
		background_debug && !sc_write |=> $stable(read_latched))
		else $error("read latch moved in debug");
	debug_read_live_a: assert property (
		background_debug && bus.rd && bus.addr == TCV_ADDR_VALUE_LOW
		|=> rdata == $past(chan_value[7:0]))
		else $error("debug read not live");
	no_clock_copy_a: assert property (
		!background_debug && pair_full && mode != TCV_MODE_CAPTURE &&
		clock_select == TCV_CLKSEL_NONE && !sc_write
		|=> chan_value == {$past(wbuf_high), $past(wbuf_low)})
		else $error("no immediate copy");
	compare_wait_a: assert property (
		mode == TCV_MODE_COMPARE && clock_select != TCV_CLKSEL_NONE &&
		!counter.step && !val_write |=> $stable(chan_value))
		else $error("compare copied without counter step");
	pwm_point_a: assert property (
		transfer && mode == TCV_MODE_EDGE_PWM &&
		clock_select != TCV_CLKSEL_NONE |-> counter.step &&
		counter.count + TCV_ONE == pwm_top)
		else $error("pwm copy off the modulo step");
	debug_bypass_a: assert property (
		background_debug && val_write && is_high &&
		mode != TCV_MODE_CAPTURE |=> chan_value[15:8] == $past(bus.wdata))
		else $error("debug write did not bypass");
	debug_write_frozen_a: assert property (
		background_debug && !sc_write |=> $stable({wgot_high, wgot_low}))
		else $error("write latch moved in debug");
	empty_after_a: assert property (
		transfer && !sc_write && !val_write |=> !wgot_high && !wgot_low)
		else $error("latch not emptied");

	// write side: buffering and copy
	copy_keeps_high_a: assert property (
		transfer && val_write && is_high && !sc_write
		|=> wgot_high && wbuf_high == $past(bus.wdata))
		else $error("high byte lost at copy");
	copy_keeps_low_a: assert property (
		transfer && val_write && !is_high && !sc_write
		|=> wgot_low && wbuf_low == $past(bus.wdata))
		else $error("low byte lost at copy");
	pair_copy_value_a: assert property (
		transfer |=> chan_value == {$past(wbuf_high), $past(wbuf_low)})
		else $error("copied value wrong");
	pair_needs_both_a: assert property (
		transfer |-> wgot_high && wgot_low)
		else $error("copy before both bytes");
	write_buffered_a: assert property (
		val_write && !background_debug && mode != TCV_MODE_CAPTURE &&
		!transfer |=> $stable(chan_value))
		else $error("buffered write reached channel");
	cap_latch_idle_a: assert property (
		mode == TCV_MODE_CAPTURE && val_write
		|=> $stable({wgot_high, wgot_low, wbuf_high, wbuf_low}))
		else $error("capture write touched buffer");
	capture_no_copy_a: assert property (
		mode == TCV_MODE_CAPTURE |-> !transfer)
		else $error("copy in capture mode");

	// copy point per clock selection and mode
	no_clock_now_a: assert property (
		pair_full && !background_debug && mode != TCV_MODE_CAPTURE &&
		clock_select == TCV_CLKSEL_NONE |-> transfer)
		else $error("no clock pair not copied");
	compare_step_a: assert property (
		transfer && mode == TCV_MODE_COMPARE &&
		clock_select != TCV_CLKSEL_NONE |-> counter.step)
		else $error("compare copy off the step");
	center_point_a: assert property (
		transfer && mode == TCV_MODE_CENTER_PWM &&
		clock_select != TCV_CLKSEL_NONE |-> counter.step &&
		counter.count + TCV_ONE == pwm_top)
		else $error("center pwm copy off the modulo step");
	pwm_free_run_a: assert property (
		transfer && mode != TCV_MODE_COMPARE && counter.free_run &&
		clock_select != TCV_CLKSEL_NONE |-> counter.count == TCV_FREE_RUN_PRE)
		else $error("free run copy off the top step");
	pwm_wait_a: assert property (
		(mode == TCV_MODE_EDGE_PWM || mode == TCV_MODE_CENTER_PWM) &&
		clock_select != TCV_CLKSEL_NONE && !pwm_point && !val_write
		|=> $stable(chan_value))
		else $error("pwm copied off the modulo step");

	// debug freezes latches except on a status/control write, writes go direct
	debug_no_copy_a: assert property (
		background_debug && !val_write |=> $stable(chan_value))
		else $error("copy during debug");
	debug_bypass_low_a: assert property (
		background_debug && val_write && !is_high &&
		mode != TCV_MODE_CAPTURE |=> chan_value[7:0] == $past(bus.wdata))
		else $error("debug low write did not bypass");
	debug_bypass_keep_a: assert property (
		background_debug && val_write && is_high &&
		mode != TCV_MODE_CAPTURE |=> chan_value[7:0] == $past(chan_value[7:0]))
		else $error("debug high write touched low byte");
	debug_sc_write_a: assert property (
		background_debug && sc_write |=> !wgot_high && !wgot_low)
		else $error("debug status write kept write latch");
	debug_sc_release_a: assert property (
		background_debug && sc_write |=> !read_latched)
		else $error("debug status write kept read latch");
	debug_live_high_a: assert property (
		background_debug && bus.rd && bus.addr == TCV_ADDR_VALUE_HIGH
		|=> rdata == $past(chan_value[15:8]))
		else $error("debug high read not live");
	read_no_latch_a: assert property (
		background_debug && val_read && !sc_write
		|=> $stable({read_buf, read_got_high, read_got_low}))
		else $error("debug read moved read buffer");

	// read side
	sc_release_buf_a: assert property (
		sc_write |=> !read_got_high && !read_got_low)
		else $error("status write kept read halves");
	read_hold_a: assert property (
		read_latched && !val_read && !sc_write |=> read_latched)
		else $error("read latch dropped without read");
	read_release_a: assert property (
		read_latched && val_read && !background_debug && !sc_write &&
		mode == TCV_MODE_CAPTURE &&
		((is_high && read_got_low) || (!is_high && read_got_high))
		|=> !read_latched)
		else $error("other half read did not release");
	read_buffered_a: assert property (
		read_latched && !background_debug && mode == TCV_MODE_CAPTURE &&
		bus.rd && bus.addr == TCV_ADDR_VALUE_HIGH
		|=> rdata == $past(read_buf[15:8]))
		else $error("high read not from buffer");
	read_buffered_low_a: assert property (
		read_latched && !background_debug && mode == TCV_MODE_CAPTURE &&
		bus.rd && bus.addr == TCV_ADDR_VALUE_LOW
		|=> rdata == $past(read_buf[7:0]))
		else $error("low read not from buffer");

	// main scenarios reached by the bench

	cov_compare_copy: cover property (transfer && mode == TCV_MODE_COMPARE);
	cov_pwm_copy: cover property (transfer && pwm_point);
	cov_cap_pair: cover property (read_latched ##[1:4] !read_latched);
	cov_debug_write: cover property (background_debug && val_write);
	cov_read_release: cover property (read_latched && val_read &&
		!background_debug && mode == TCV_MODE_CAPTURE);

endmodule
`default_nettype wire

// ---- tcv_pkg.sv ----
package tcv_pkg;
	// register index on the 8-bit processor port
	localparam logic [1:0] TCV_ADDR_STATUS_CONTROL = 2'h0;
	localparam logic [1:0] TCV_ADDR_VALUE_HIGH = 2'h1;
	localparam logic [1:0] TCV_ADDR_VALUE_LOW = 2'h2;
	localparam logic [1:0] TCV_ADDR_MODE = 2'h3;
	// status/control field positions
	localparam int TCV_CS_CLKSEL_LO = 0;
	localparam int TCV_CS_CLKSEL_HI = 1;
	localparam logic [1:0] TCV_CLKSEL_NONE = 2'h0;
	localparam logic [7:0] TCV_BYTE_RESET = 8'h00;
	localparam logic [15:0] TCV_VALUE_RESET = 16'h0000;
	localparam logic [15:0] TCV_FREE_RUN_PRE = 16'hfffe;
	localparam logic [15:0] TCV_FREE_RUN_TOP = 16'hffff;
	localparam logic [15:0] TCV_ONE = 16'h0001;

	typedef enum logic [1:0] {
		TCV_MODE_CAPTURE,
		TCV_MODE_COMPARE,
		TCV_MODE_EDGE_PWM,
		TCV_MODE_CENTER_PWM
	} tcv_mode_t;

	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tcv_bus_t;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] modulo;
		logic step;
		logic free_run;
	} tcv_counter_t;
endpackage

// ---- tcv_timer_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// timer stand-in: one counter step every fourth clock (prescaler end)
module tcv_timer_model import tcv_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic resetn,
	// setup
	input wire logic [15:0] modulo,
	input wire logic free_run,
	// counter to the channel
	output tcv_counter_t counter
);
	logic [1:0] pre;
	logic [15:0] count;
	logic [15:0] top;
	logic step;
	assign top = free_run ? TCV_FREE_RUN_TOP : modulo;
	assign step = (pre == 2'h3);
	assign counter = '{count, modulo, step, free_run};
	always_ff @(posedge clock) begin
		if (!resetn) begin
			pre <= 2'h0;
			count <= 16'h0000;
		end else begin
			pre <= pre + 2'h1;
			if (step) begin
				count <= (count == top) ? 16'h0000 : count + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// ---- test_tcv_channel.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_tcv_channel import tcv_pkg::*;;
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic background_debug = 1'b0;
	logic free_run = 1'b0;
	logic [15:0] modulo = 16'h0008;
	tcv_bus_t bus = '0;
	tcv_counter_t counter;
	logic [7:0] rdata;
	logic [15:0] chan_value;
	int n_fail = 0;
	int checked = 0;
	always #2.5 clock = ~clock;
	tcv_timer_model tmr_u (.clock(clock), .resetn(resetn), .modulo(modulo),
		.free_run(free_run), .counter(counter));
	tcv_channel dut_u (.clock(clock), .resetn(resetn), .bus(bus),
		.rdata(rdata), .counter(counter),
		.background_debug(background_debug), .chan_value(chan_value));
	////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish();
		$display("checked %0d, failed %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk16(input logic [15:0] exp);
		#1;
		checked++;
		if (chan_value !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t value %h exp %h", $time, chan_value, exp);
		end
	endtask
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		bus <= '{a, d, 1'b1, 1'b0};
		@(posedge clock);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clock);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clock);
		bus.rd <= 1'b0;
		#1;
		checked++;
		if (rdata !== exp) begin
			n_fail++;
			$display("CHECK FAILED %0t read %h exp %h", $time, rdata, exp);
		end
	endtask
	// bounded wait; a miss counts and ends the run
	task automatic wait_val(input logic [15:0] exp);
		for (int i = 0; i < 300 && chan_value !== exp; i++) @(posedge clock);
		#1;
		chk16(exp);
		if (chan_value !== exp) tally_and_finish();
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_pair_now();
		wr(TCV_ADDR_MODE, 8'h01);
		wr(TCV_ADDR_VALUE_HIGH, 8'h00);
		wr(TCV_ADDR_VALUE_LOW, 8'h00);
		wait_val(16'h0000);
		wr(TCV_ADDR_VALUE_LOW, 8'hcd);
		repeat (3) @(posedge clock);
		chk16(16'h0000);
		wr(TCV_ADDR_VALUE_HIGH, 8'hab);
		repeat (2) @(posedge clock);
		chk16(16'habcd);
		wr(TCV_ADDR_VALUE_HIGH, 8'h11);
		repeat (3) @(posedge clock);
		chk16(16'habcd);
		$display("test pair_now done");
	endtask
	task automatic t_debug();
		wr(TCV_ADDR_VALUE_LOW, 8'h00);
		wait_val(16'h1100);
		wr(TCV_ADDR_VALUE_HIGH, 8'h12);
		background_debug <= 1'b1;
		wr(TCV_ADDR_VALUE_LOW, 8'h34);
		wait_val(16'h1134);
		rd(TCV_ADDR_VALUE_HIGH, 8'h11);
		@(posedge clock);
		background_debug <= 1'b0;
		wr(TCV_ADDR_VALUE_LOW, 8'h56);
		wait_val(16'h1256);
		$display("test debug done");
	endtask
	task automatic t_release();
		wr(TCV_ADDR_VALUE_HIGH, 8'h77);
		wr(TCV_ADDR_STATUS_CONTROL, 8'h00);
		wr(TCV_ADDR_VALUE_LOW, 8'h88);
		repeat (3) @(posedge clock);
		chk16(16'h1256);
		wr(TCV_ADDR_VALUE_HIGH, 8'h99);
		wait_val(16'h9988);
		$display("test release done");
	endtask
	task automatic t_capture();
		wr(TCV_ADDR_MODE, 8'h00);
		wr(TCV_ADDR_VALUE_HIGH, 8'h5a);
		wr(TCV_ADDR_VALUE_LOW, 8'h5b);
		repeat (3) @(posedge clock);
		chk16(16'h9988);
		rd(TCV_ADDR_VALUE_LOW, 8'h88);
		wr(TCV_ADDR_MODE, 8'h01);
		wr(TCV_ADDR_VALUE_HIGH, 8'h22);
		wr(TCV_ADDR_VALUE_LOW, 8'h33);
		wait_val(16'h2233);
		wr(TCV_ADDR_MODE, 8'h00);
		background_debug <= 1'b1;
		rd(TCV_ADDR_VALUE_HIGH, 8'h22);
		@(posedge clock);
		background_debug <= 1'b0;
		rd(TCV_ADDR_VALUE_HIGH, 8'h99);
		rd(TCV_ADDR_VALUE_LOW, 8'h33);
		$display("test capture done");
	endtask
	task automatic t_clocked();
		wr(TCV_ADDR_MODE, 8'h01);
		wr(TCV_ADDR_STATUS_CONTROL, 8'h01);
		wr(TCV_ADDR_VALUE_HIGH, 8'h01);
		wr(TCV_ADDR_VALUE_LOW, 8'h23);
		wait_val(16'h0123);
		for (int m = 2; m < 4; m++) begin
			wr(TCV_ADDR_MODE, 8'(m));
			wr(TCV_ADDR_VALUE_LOW, 8'(m));
			wr(TCV_ADDR_VALUE_HIGH, 8'h40);
			wait_val({8'h40, 8'(m)});
		end
		$display("test clocked done");
	endtask
	initial begin
		repeat (6) @(posedge clock);
		resetn <= 1'b1;
		t_pair_now();
		t_debug();
		t_release();
		t_capture();
		t_clocked();
		tally_and_finish();
	end
endmodule
`default_nettype wire
